// ===== src/erm_pkg.sv
// Package for the equipment rotation member: widths, reset values, timing.
// Assumes a 100 MHz system clock; all counts derive from it.
package erm_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ         = 100_000_000;
    localparam int unsigned MINUTE_S       = 60;
    localparam longint unsigned MINUTE_CYC = longint'(CLK_HZ) * MINUTE_S;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int unsigned TIME_W      = 16;
    localparam int unsigned SEL_W       = 10;
    localparam int unsigned AGING_DEF   = 2;
    localparam int unsigned TIMEOUT_DEF = 1;
    localparam logic [TIME_W-1:0] TIME_ZERO = 16'h0000;

    typedef enum logic [1:0] {
        ERM_IDLE,
        ERM_RUN,
        ERM_DONE
    } erm_state_e;

endpackage : erm_pkg

// ===== src/erm_member.sv
// Equipment rotation member: runs its equipment for an aging time in turn,
// counts run minutes, supervises feedback and fault, latches an error.
// Assumes all inputs synchronous to clk; the manager's select word comes
// from the rotation manager only.

// Overview of operation
// - Member rotates only while activate is high; inactive when low.
// - Deactivation switches equipment off; other members keep rotating without it.
// - Aging time is minutes; run that long on turn, then stop, pass turn.
// - Aging time comes from an internal setting or the aging time input.
// - After every member finishes, rotation wraps and restarts cyclically.
// - Run time output shows accumulated running minutes.
// - Each rising edge on run time reset clears run time to zero.
// - Higher existing age gives shorter runs, balancing run times.
// - Running feedback is the equipment's actual on/off level.
// - Fault high sets error and forces on/off output low.
// - Error stays latched after fault returns low until reset.
// - Rising edge on error reset clears the latched error.
// - On without feedback beyond the timeout sets the error.
module erm_member #(
    parameter int unsigned         SEL_W      = erm_pkg::SEL_W,
    parameter int unsigned         MEMBER_IDX = 0,
    parameter longint unsigned     MINUTE_CYC = erm_pkg::MINUTE_CYC,
    parameter logic [15:0]         AGING_INT  = 16'(erm_pkg::AGING_DEF),
    parameter logic [15:0]         TMO_INT    = 16'(erm_pkg::TIMEOUT_DEF)
) (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              clk_en,
    input  wire logic [SEL_W-1:0]  manager_member_select_out,
    input  wire logic              running_feedback_in,
    input  wire logic              fault_in,
    input  wire logic              activate_in,
    input  wire logic              aging_ext_sel,
    input  wire logic [15:0]       aging_time_in,
    input  wire logic              run_time_reset_in,
    input  wire logic [15:0]       current_age_in,
    input  wire logic [15:0]       fleet_min_age_in,
    input  wire logic              error_reset_in,
    input  wire logic [15:0]       error_timeout_in,
    output logic [15:0]            run_time_out,
    output logic                   on_off_out,
    output logic                   error_out,
    output logic                   turn_done_out
);

    // ------------------------------------------------------------------
    // Minute tick
    // ------------------------------------------------------------------
    localparam int unsigned TICK_W = $clog2(MINUTE_CYC + 1);

    logic [TICK_W-1:0] tick_cnt_r;
    logic              tick_r;
    logic [TICK_W-1:0] tick_cnt_nxt;
    // Free-running, so the first minute of a run may be short
    wire               tick_wrap = (tick_cnt_r == TICK_W'(MINUTE_CYC - 1));

    always_comb begin
        tick_cnt_nxt = tick_cnt_r + TICK_W'(1);
        if (tick_wrap) begin
            tick_cnt_nxt = '0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tick_cnt_r <= '0;
            tick_r     <= 1'b0;
        end else if (clk_en) begin
            tick_cnt_r <= tick_cnt_nxt;
            tick_r     <= tick_wrap;
        end
    end

    // ------------------------------------------------------------------
    // Edge detection on reset inputs
    // ------------------------------------------------------------------
    localparam int unsigned EDGE_N = 2;

    wire [EDGE_N-1:0] edge_in = {error_reset_in, run_time_reset_in};
    wire [EDGE_N-1:0] edge_rise;

    // Previous sample resets low, the idle level, so no false edge follows reset
    for (genvar g = 0; g < EDGE_N; g++) begin : g_edge
        logic prev_r;

        assign edge_rise[g] = edge_in[g] & ~prev_r;

        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                prev_r <= 1'b0;
            end else if (clk_en) begin
                prev_r <= edge_in[g];
            end
        end
    end

    wire rt_rst_rise  = edge_rise[0];
    wire err_rst_rise = edge_rise[1];

    // ------------------------------------------------------------------
    // Turn selection
    // ------------------------------------------------------------------
    // Manager reports this member's turn as its own bit of the select word
    wire        my_turn   = manager_member_select_out[MEMBER_IDX];
    wire [15:0] aging_min = aging_ext_sel ? aging_time_in : AGING_INT;
    // Balancing: aging period shortened by how far this member leads the
    // least-worn one; never below one minute so a turn always completes.
    wire [15:0] age_lead  = (current_age_in > fleet_min_age_in) ?
                            current_age_in - fleet_min_age_in : 16'h0000;
    wire [15:0] run_limit = (aging_min > age_lead + 16'h0001) ?
                            aging_min - age_lead : 16'h0001;
    // Zero on the timeout input selects the built-in setting
    wire [15:0] tmo_min   = (error_timeout_in != 16'h0000) ?
                            error_timeout_in : TMO_INT;

    // ------------------------------------------------------------------
    // Turn state machine
    // ------------------------------------------------------------------
    erm_pkg::erm_state_e state_r;
    erm_pkg::erm_state_e state_nxt;
    logic [15:0]         aging_cnt_r;
    logic                error_r;

    // A latched error refuses the turn until it is cleared
    wire can_run  = activate_in & ~error_r & ~fault_in;
    // Checked as a level so a shortened limit ends a turn at once
    wire aged_out = (aging_cnt_r >= run_limit);

    // Turn state: idle, running, finished and waiting for the manager
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            erm_pkg::ERM_IDLE: begin
                if (my_turn && can_run) begin
                    state_nxt = erm_pkg::ERM_RUN;
                end
            end
            erm_pkg::ERM_RUN: begin
                if (!can_run) begin
                    state_nxt = erm_pkg::ERM_IDLE;
                end else if (aged_out) begin
                    state_nxt = erm_pkg::ERM_DONE;
                end
            end
            erm_pkg::ERM_DONE: begin
                // Wait for manager to move on, so the next cycle restarts
                if (!my_turn) begin
                    state_nxt = erm_pkg::ERM_IDLE;
                end
            end
            default: state_nxt = erm_pkg::ERM_IDLE;
        endcase
    end

    wire running = (state_r == erm_pkg::ERM_RUN);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= erm_pkg::ERM_IDLE;
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end

    logic [15:0]         aging_cnt_nxt;

    always_comb begin
        aging_cnt_nxt = aging_cnt_r;
        if (!running) begin
            aging_cnt_nxt = erm_pkg::TIME_ZERO;
        end else if (tick_r) begin
            aging_cnt_nxt = aging_cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            aging_cnt_r <= erm_pkg::TIME_ZERO;
        end else if (clk_en) begin
            aging_cnt_r <= aging_cnt_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Run time accumulation
    // ------------------------------------------------------------------
    logic [15:0] run_time_r;
    logic [15:0] run_time_nxt;
    // Saturate rather than wrap so a worn unit never reads as new
    wire         run_time_full = (run_time_r == 16'hFFFF);

    always_comb begin
        run_time_nxt = run_time_r;
        if (rt_rst_rise) begin
            run_time_nxt = erm_pkg::TIME_ZERO;
        end else if (on_off_out && tick_r && !run_time_full) begin
            run_time_nxt = run_time_r + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            run_time_r <= erm_pkg::TIME_ZERO;
        end else if (clk_en) begin
            run_time_r <= run_time_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Feedback supervision and error latch
    // ------------------------------------------------------------------
    logic [15:0] fb_wait_r;
    logic [15:0] fb_wait_nxt;
    wire         fb_wait_full = (fb_wait_r == 16'hFFFF);
    wire         fb_tmo = on_off_out && !running_feedback_in
                          && (fb_wait_r >= tmo_min);

    always_comb begin
        fb_wait_nxt = fb_wait_r;
        if (!on_off_out || running_feedback_in) begin
            fb_wait_nxt = erm_pkg::TIME_ZERO;
        end else if (tick_r && !fb_wait_full) begin
            fb_wait_nxt = fb_wait_r + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fb_wait_r <= erm_pkg::TIME_ZERO;
        end else if (clk_en) begin
            fb_wait_r <= fb_wait_nxt;
        end
    end

    logic error_nxt;

    // Set beats clear: a fault still present keeps the error up
    always_comb begin
        error_nxt = error_r;
        if (fault_in || fb_tmo) begin
            error_nxt = 1'b1;
        end else if (err_rst_rise) begin
            error_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            error_r <= 1'b0;
        end else if (clk_en) begin
            error_r <= error_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // On/off, error and done registered from next values, so they move with the state; run time lags one clock
    wire on_off_nxt    = (state_nxt == erm_pkg::ERM_RUN) && !fault_in;
    // Done also when unable to run, so the manager can move on
    wire turn_done_nxt = (state_nxt == erm_pkg::ERM_DONE) || (my_turn && !can_run);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            on_off_out <= 1'b0;
        end else if (clk_en) begin
            on_off_out <= on_off_nxt;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            error_out <= 1'b0;
        end else if (clk_en) begin
            error_out <= error_nxt;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            run_time_out <= erm_pkg::TIME_ZERO;
        end else if (clk_en) begin
            run_time_out <= run_time_r;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            turn_done_out <= 1'b0;
        end else if (clk_en) begin
            turn_done_out <= turn_done_nxt;
        end
    end

endmodule // erm_member

// ===== dv/erm_partner.sv
// Rotation manager with one other member, plus the driven equipment.
// Assumes the member under test owns select bit 0.
module erm_partner (
    input  wire logic  clk,
    input  wire logic  rstn,
    input  wire logic  turn_done,
    input  wire logic  on_off,
    input  wire logic  dead,
    output logic [9:0] sel,
    output logic       fb
);
    timeunit 1ns;
    timeprecision 1ns;
    int other;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sel   <= 10'h001;
            other <= 0;
            fb    <= 1'b0;
        end else begin
            fb <= on_off & !dead;
            if (sel[0] && turn_done) begin
                sel   <= 10'h002;
                other <= 5;
            end else if (other > 0) begin
                other <= other - 1;
            end else if (sel[1]) begin
                sel <= 10'h001;
            end
        end
    end
endmodule // erm_partner

// ===== dv/erm_member_assertions.sv
// Checker for the rotation member, bound to its ports.
// Assumes clk_en held high, so samples and design edges line up.
module erm_member_assertions #(
    parameter longint unsigned MINUTE_CYC = 20
) (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        clk_en,
    input wire logic [9:0]  manager_member_select_out,
    input wire logic        running_feedback_in,
    input wire logic        fault_in,
    input wire logic        activate_in,
    input wire logic        run_time_reset_in,
    input wire logic        error_reset_in,
    input wire logic [15:0] error_timeout_in,
    input wire logic [15:0] run_time_out,
    input wire logic        on_off_out,
    input wire logic        error_out,
    input wire logic        turn_done_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [31:0] dry_r;
    wire  [31:0] tmo_min = (error_timeout_in == 16'h0000) ? 32'h1 : 32'(error_timeout_in);
    // Free ticker: allow one extra partial minute
    wire  [31:0] dry_lim = (tmo_min + 32'h1) * 32'(MINUTE_CYC) + 32'h4;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) dry_r <= '0;
        else dry_r <= (on_off_out && !running_feedback_in) ? dry_r + 32'h1 : '0;
    end
    a_fault_sets_error: assert property (
        clk_en && fault_in |=> error_out && !on_off_out)
        else $error("fault did not latch error");
    a_error_holds: assert property (
        clk_en && error_out && !$rose(error_reset_in) |=> error_out)
        else $error("error dropped without reset edge");
    a_refused_clear: assert property (error_out && fault_in |=> error_out)
        else $error("error cleared while fault present");
    a_error_clears: assert property (
        clk_en && error_out && $rose(error_reset_in) && !fault_in && !on_off_out
        |=> !error_out)
        else $error("error reset edge ignored");
    a_inactive_off: assert property (clk_en && !activate_in |=> !on_off_out)
        else $error("inactive member runs");
    a_turn_start: assert property (
        clk_en && manager_member_select_out[0] && activate_in && !error_out && !fault_in
        && !turn_done_out && !on_off_out |=> on_off_out)
        else $error("turn not taken");
    a_start_cause: assert property (
        $rose(on_off_out) |-> $past(activate_in) && $past(manager_member_select_out[0]))
        else $error("start without turn");
    a_run_step: assert property (
        !$stable(run_time_out) |-> run_time_out == 16'h0000
        || run_time_out == $past(run_time_out) + 16'h0001)
        else $error("run time jumped");
    a_run_clear: assert property (
        clk_en && $rose(run_time_reset_in) |-> ##[1:2] run_time_out == 16'h0000)
        else $error("run time not cleared");
    a_dry_bound: assert property (dry_r <= dry_lim)
        else $error("feedback timeout missed");
    c_start: cover property ($rose(on_off_out));
    c_error: cover property ($rose(error_out));
    c_clear: cover property ($fell(error_out));
    c_done: cover property ($rose(turn_done_out));
endmodule // erm_member_assertions

bind erm_member erm_member_assertions #(.MINUTE_CYC(MINUTE_CYC)) chk_u (
    .clk(clk), .rstn(rstn), .clk_en(clk_en),
    .manager_member_select_out(manager_member_select_out),
    .running_feedback_in(running_feedback_in), .fault_in(fault_in),
    .activate_in(activate_in), .run_time_reset_in(run_time_reset_in),
    .error_reset_in(error_reset_in), .error_timeout_in(error_timeout_in),
    .run_time_out(run_time_out), .on_off_out(on_off_out), .error_out(error_out),
    .turn_done_out(turn_done_out)
);

// ===== dv/erm_member_tb_top.sv
// Bench for the rotation member: table of level cases, then error latch,
// reset, rotation, run time clear and feedback timeout. Minute is 20 clocks.
module erm_member_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MC = 20;
    logic        clk = 0, rstn = 0, clk_en = 1, fault = 0, act = 0, ext = 1;
    logic        rt_rst = 0, er_rst = 0, dead = 0, fb, done, on, err;
    logic [15:0] agi = 16'h0064, age = 16'h0000, minage = 16'h0000, tmo = 16'h0000;
    logic [15:0] rt, rt0;
    logic [9:0]  sel;
    logic [3:0]  rows [3] = '{4'b1010, 4'b0000, 4'b1101};
    int          miscompares = 0, comparisons = 0, cyc = 0, n;
    erm_member #(.MINUTE_CYC(MC)) dut_u (
        .clk(clk), .rstn(rstn), .clk_en(clk_en), .manager_member_select_out(sel),
        .running_feedback_in(fb), .fault_in(fault), .activate_in(act),
        .aging_ext_sel(ext), .aging_time_in(agi), .run_time_reset_in(rt_rst),
        .current_age_in(age), .fleet_min_age_in(minage), .error_reset_in(er_rst),
        .error_timeout_in(tmo), .run_time_out(rt), .on_off_out(on), .error_out(err),
        .turn_done_out(done));
    erm_partner part_u (.clk(clk), .rstn(rstn), .turn_done(done), .on_off(on),
        .dead(dead), .sel(sel), .fb(fb));
    initial forever #5 clk = ~clk;
    task automatic cy(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wait_on(input logic lvl);
        n = 0;
        while (on !== lvl && n < 200) begin
            cy(1);
            n++;
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Hang guard, well above the expected run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            complete_run();
        end
    end
    initial begin
        cy(6);
        rstn = 1;
        foreach (rows[i]) begin
            {act, fault} = rows[i][3:2];
            cy(3);
            chk(16'({on, err}), 16'(rows[i][1:0]));
            fault = 0;
            cy(1);
            er_rst = 1;
            cy(2);
            er_rst = 0;
        end
        fault = 1;
        cy(2);
        fault = 0;
        cy(4);
        chk(16'(err), 16'h0001);
        fault = 1;
        er_rst = 1;
        cy(2);
        chk(16'(err), 16'h0001);
        {fault, er_rst} = 2'b00;
        cy(1);
        er_rst = 1;
        cy(2);
        chk(16'(err), 16'h0000);
        {er_rst, rstn} = 2'b00;
        cy(1);
        chk(rt, 16'h0000);
        chk(16'({on, err, done}), 16'h0000);
        {rstn, ext, age} = {2'b10, 16'h0001};
        wait_on(1'b1);
        rt0 = rt;
        wait_on(1'b0);
        chk(16'(done), 16'h0001);
        chk(16'(n >= 1 && n <= MC + 2), 16'h0001);
        cy(2);
        chk(rt, rt0 + 16'h0001);
        age = 16'h0000;
        wait_on(1'b1);
        chk(16'(on), 16'h0001);
        rt0 = rt;
        wait_on(1'b0);
        chk(16'(n > MC && n <= 2 * MC + 2), 16'h0001);
        cy(2);
        chk(rt, rt0 + 16'h0002);
        act = 0;
        cy(2);
        rt_rst = 1;
        cy(3);
        chk(rt, 16'h0000);
        {rt_rst, act, ext, dead, tmo} = {4'b0111, 16'h0001};
        wait_on(1'b1);
        n = 0;
        while (err !== 1'b1 && n < 100) begin
            cy(1);
            n++;
        end
        cy(1);
        chk(16'({err, on, 1'(n <= 2 * MC + 4)}), 16'h0005);
        dead = 0;
        cy(2);
        complete_run();
    end
endmodule // erm_member_tb_top
